//--- rtl/csc_top.sv
// Capacitive sense control, timer source routing and Avalon-MM register slave.
`timescale 1ns/10ps
module csc_top (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [csc_pkg::BUS_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [csc_pkg::BUS_DATA_W-1:0] avs_writedata_i,
    input wire logic [csc_pkg::BUS_BE_W-1:0] avs_byteenable_i,
    output logic [csc_pkg::BUS_DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic osc_dir_i,
    input wire logic timer0_ext_clock_i,
    input wire logic timer1_gate_i,
    input wire logic sleep_i,
    output logic osc_run_o,
    output logic ref_variable_o,
    output logic current_source_o,
    output logic [1:0] current_level_o,
    output logic [csc_pkg::TIMER0_W-1:0] timer0_count_o,
    output logic timer0_overflow_o,
    output logic [csc_pkg::TIMER1_W-1:0] timer1_count_o,
    output logic timer1_overflow_o
);
    import csc_pkg::*;

    logic [CTRL_W-1:0] sense_control0;
    logic [CTRL_W-1:0] timer_config;
    logic t0_overflow_flag;
    logic wait_q;
    logic bus_req;
    logic wr_ack;
    logic osc_s;
    logic osc_prev;
    logic pin_s;
    logic pin_prev;
    logic sense_pulse;
    logic pin_pulse;
    logic [1:0] div_cnt;
    logic fosc4_pulse;
    logic timer0_inc;
    logic timer1_inc;
    logic timer1_enabled;
    logic timer0_load;
    logic timer1_load;
    logic [TIMER1_W-1:0] timer1_load_value;
    csc_osc_mode_e next_mode;
    logic [CTRL_W-1:0] ctrl_view;
    logic [BUS_DATA_W-1:0] next_readdata;

    wire module_enable = sense_control0[BIT_MODULE_ENABLE];
    wire reference_mode_select = sense_control0[BIT_REFERENCE_MODE];
    wire [1:0] current_range_select = sense_control0[BIT_RANGE_HI:BIT_RANGE_LO];
    wire timer0_external_source_select = sense_control0[BIT_T0_EXT_SELECT];
    wire timer0_clock_source_bit = timer_config[BIT_T0_CLOCK_SOURCE];
    wire [1:0] timer1_clock_select = timer_config[BIT_T1_SELECT_HI:BIT_T1_SELECT_LO];
    wire timer1_on_bit = timer_config[BIT_T1_ON];
    wire timer1_gate_enable = timer_config[BIT_T1_GATE_ENABLE];

    assign bus_req = avs_read_i || avs_write_i;
    assign wr_ack = avs_write_i && !wait_q;

    // One wait state: waitrequest drops for exactly one cycle per request.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !(bus_req && wait_q);
        end
    end
    assign avs_waitrequest_o = wait_q;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sense_control0 <= CTRL_RESET;
        end else if (wr_ack && avs_address_i == OFS_SENSE_CONTROL0 && avs_byteenable_i[0]) begin
            sense_control0[BIT_MODULE_ENABLE] <= avs_writedata_i[BIT_MODULE_ENABLE];
            sense_control0[BIT_REFERENCE_MODE] <= avs_writedata_i[BIT_REFERENCE_MODE];
            sense_control0[BIT_RANGE_HI:BIT_RANGE_LO] <= avs_writedata_i[BIT_RANGE_HI:BIT_RANGE_LO];
            sense_control0[BIT_T0_EXT_SELECT] <= avs_writedata_i[BIT_T0_EXT_SELECT];
        end
    end

    // Unimplemented and read-only positions are never written, so they stay zero.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timer_config <= TCFG_RESET;
        end else if (wr_ack && avs_address_i == OFS_TIMER_CONFIG && avs_byteenable_i[0]) begin
            timer_config[BIT_T0_CLOCK_SOURCE] <= avs_writedata_i[BIT_T0_CLOCK_SOURCE];
            timer_config[BIT_T1_SELECT_HI:BIT_T1_SELECT_LO] <= avs_writedata_i[BIT_T1_SELECT_HI:BIT_T1_SELECT_LO];
            timer_config[BIT_T1_ON] <= avs_writedata_i[BIT_T1_ON];
            timer_config[BIT_T1_GATE_ENABLE] <= avs_writedata_i[BIT_T1_GATE_ENABLE];
        end
    end

    // Overflow flag is cleared by writing zero; a new overflow in that cycle wins.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            t0_overflow_flag <= 1'b0;
        end else if (timer0_overflow_o) begin
            t0_overflow_flag <= 1'b1;
        end else if (wr_ack && avs_address_i == OFS_TIMER_CONFIG && avs_byteenable_i[0]
                     && !avs_writedata_i[BIT_T0_OVERFLOW]) begin
            t0_overflow_flag <= 1'b0;
        end
    end

    csc_sync #(
        .WIDTH(2)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i({timer0_ext_clock_i, osc_dir_i}),
        .sync_o({pin_s, osc_s})
    );

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_prev <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            osc_prev <= osc_s;
            pin_prev <= pin_s;
        end
    end

    // Each source makes its own single-cycle pulse, so changing the mux cannot create an edge.
    assign sense_pulse = osc_s && !osc_prev && osc_run_o;
    assign pin_pulse = pin_s && !pin_prev;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt <= 2'h0;
        end else begin
            div_cnt <= div_cnt + 2'h1;
        end
    end
    assign fosc4_pulse = (div_cnt == FOSC_DIV_LAST);

    always_comb begin
        next_mode = CSC_OSC_OFF;
        if (module_enable) begin
            unique case (current_range_select)
                RANGE_CODE_ZERO: next_mode = reference_mode_select ? CSC_OSC_NOISE : CSC_OSC_OFF;
                RANGE_CODE_LOW: next_mode = CSC_OSC_LOW;
                RANGE_CODE_MEDIUM: next_mode = CSC_OSC_MEDIUM;
                RANGE_CODE_HIGH: next_mode = CSC_OSC_HIGH;
            endcase
        end
    end

    // The oscillator does not look at sleep_i: it runs whenever next_mode is not CSC_OSC_OFF.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_run_o <= 1'b0;
            current_source_o <= 1'b0;
            current_level_o <= RANGE_CODE_ZERO;
            ref_variable_o <= 1'b0;
        end else begin
            osc_run_o <= (next_mode != CSC_OSC_OFF);
            current_source_o <= (next_mode != CSC_OSC_OFF) && (next_mode != CSC_OSC_NOISE);
            // No level is reported while the module is off or no current flows.
            current_level_o <= (next_mode == CSC_OSC_OFF || next_mode == CSC_OSC_NOISE) ? RANGE_CODE_ZERO
                               : current_range_select;
            ref_variable_o <= module_enable && reference_mode_select;
        end
    end

    always_comb begin
        timer0_inc = 1'b0;
        if (!sleep_i) begin
            if (timer0_clock_source_bit) begin
                timer0_inc = timer0_external_source_select ? sense_pulse : pin_pulse;
            end else begin
                timer0_inc = fosc4_pulse;
            end
        end
    end

    assign timer1_enabled = timer1_on_bit && (!timer1_gate_enable || timer1_gate_i);

    always_comb begin
        timer1_inc = 1'b0;
        if (timer1_enabled) begin
            unique case (timer1_clock_select)
                T1_SEL_FOSC4: timer1_inc = fosc4_pulse;
                T1_SEL_FOSC: timer1_inc = 1'b1;
                T1_SEL_PIN: timer1_inc = pin_pulse;
                T1_SEL_SENSE: timer1_inc = sense_pulse;
            endcase
        end
    end

    assign timer0_load = wr_ack && avs_address_i == OFS_TIMER0_COUNT && avs_byteenable_i[0];
    assign timer1_load = wr_ack && avs_address_i == OFS_TIMER1_COUNT && (|avs_byteenable_i[1:0]);
    assign timer1_load_value = {avs_byteenable_i[1] ? avs_writedata_i[15:8] : timer1_count_o[15:8],
                                avs_byteenable_i[0] ? avs_writedata_i[7:0] : timer1_count_o[7:0]};

    csc_counter #(
        .WIDTH(TIMER0_W)
    ) u_timer0 (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .inc_i(timer0_inc),
        .load_i(timer0_load),
        .load_value_i(avs_writedata_i[TIMER0_W-1:0]),
        .count_o(timer0_count_o),
        .wrap_o(timer0_overflow_o)
    );

    csc_counter #(
        .WIDTH(TIMER1_W)
    ) u_timer1 (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .inc_i(timer1_inc),
        .load_i(timer1_load),
        .load_value_i(timer1_load_value),
        .count_o(timer1_count_o),
        .wrap_o(timer1_overflow_o)
    );

    always_comb begin
        ctrl_view = sense_control0;
        ctrl_view[BIT_DIRECTION_STATUS] = osc_s && osc_run_o;
        next_readdata = '0;
        unique case (avs_address_i)
            OFS_SENSE_CONTROL0: next_readdata[CTRL_W-1:0] = ctrl_view;
            OFS_TIMER_CONFIG: begin
                next_readdata[CTRL_W-1:0] = timer_config;
                next_readdata[BIT_T0_OVERFLOW] = t0_overflow_flag;
            end
            OFS_TIMER0_COUNT: next_readdata[TIMER0_W-1:0] = timer0_count_o;
            OFS_TIMER1_COUNT: next_readdata[TIMER1_W-1:0] = timer1_count_o;
            default: next_readdata = '0;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && wait_q) begin
            avs_readdata_o <= next_readdata;
        end
    end

    sequence req_start_s;
        bus_req && wait_q;
    endsequence

    sequence ack_s;
        !avs_waitrequest_o;
    endsequence

    property one_wait_p;
        @(posedge sys_clk_i) disable iff (!rst_n_i) req_start_s |=> ack_s ##1 avs_waitrequest_o;
    endproperty

    bus_one_wait_a: assert property (one_wait_p)
        else $error("Request not answered after exactly one wait state.");

    ref_mode_out_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ref_variable_o == $past(module_enable && reference_mode_select))
        else $error("Reference mode output does not follow the control bit.");

    fixed_off_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (module_enable && !reference_mode_select && current_range_select == RANGE_CODE_ZERO)
        |=> !osc_run_o && !current_source_o)
        else $error("Oscillator runs in fixed mode with range zero.");

    range_level_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (module_enable && current_range_select != RANGE_CODE_ZERO)
        |=> osc_run_o && current_source_o && current_level_o == $past(current_range_select))
        else $error("Current level does not match the selected range.");

    noise_mode_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (module_enable && reference_mode_select && current_range_select == RANGE_CODE_ZERO)
        |=> osc_run_o && !current_source_o)
        else $error("Noise mode must keep oscillator on without current source.");

    disable_off_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !module_enable |=> !osc_run_o ##1 !sense_pulse)
        else $error("Disabled module still runs or counts.");

    status_read_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (avs_read_i && wait_q && avs_address_i == OFS_SENSE_CONTROL0)
        |=> avs_readdata_o[BIT_DIRECTION_STATUS] == $past(osc_s && osc_run_o))
        else $error("Direction status read does not show the oscillator.");

    reserved_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (avs_read_i && wait_q && avs_address_i == OFS_SENSE_CONTROL0)
        |=> avs_readdata_o[5:4] == 2'b00 && avs_readdata_o[31:8] == 24'h00_0000)
        else $error("Unimplemented control bits read nonzero.");

    t0_source_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (timer0_inc && timer0_clock_source_bit)
        |-> (timer0_external_source_select ? sense_pulse : pin_pulse))
        else $error("Timer0 counted from the wrong external source.");

    t1_sense_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (timer1_enabled && timer1_clock_select == T1_SEL_SENSE && sense_pulse && !timer1_load)
        |=> timer1_count_o == $past(timer1_count_o) + 16'h0001)
        else $error("Timer1 missed a sense oscillator edge.");

    t1_gate_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (!timer1_load && (!timer1_on_bit || (timer1_gate_enable && !timer1_gate_i)))
        |=> $stable(timer1_count_o))
        else $error("Timer1 counted while off or gated.");

    t0_sleep_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (sleep_i && !timer0_load) |=> $stable(timer0_count_o))
        else $error("Timer0 counted during sleep.");

    sleep_run_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (sleep_i && module_enable && current_range_select != RANGE_CODE_ZERO) |=> osc_run_o)
        else $error("Oscillator stopped during sleep.");

    pulse_single_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        sense_pulse |=> !sense_pulse)
        else $error("Sense pulse lasted more than one cycle.");
endmodule

//--- rtl/csc_pkg.sv
// Constants for the capacitive sense control block.
package csc_pkg;
    localparam int unsigned BUS_ADDR_W = 4;
    localparam int unsigned BUS_DATA_W = 32;
    localparam int unsigned BUS_BE_W = 4;
    localparam logic [3:0] OFS_SENSE_CONTROL0 = 4'h0;
    localparam logic [3:0] OFS_TIMER_CONFIG = 4'h4;
    localparam logic [3:0] OFS_TIMER0_COUNT = 4'h8;
    localparam logic [3:0] OFS_TIMER1_COUNT = 4'hC;
    localparam int unsigned CTRL_W = 8;
    localparam int unsigned BIT_MODULE_ENABLE = 7;
    localparam int unsigned BIT_REFERENCE_MODE = 6;
    localparam int unsigned BIT_RANGE_HI = 3;
    localparam int unsigned BIT_RANGE_LO = 2;
    localparam int unsigned BIT_DIRECTION_STATUS = 1;
    localparam int unsigned BIT_T0_EXT_SELECT = 0;
    localparam int unsigned BIT_T0_CLOCK_SOURCE = 0;
    localparam int unsigned BIT_T1_SELECT_HI = 2;
    localparam int unsigned BIT_T1_SELECT_LO = 1;
    localparam int unsigned BIT_T1_ON = 3;
    localparam int unsigned BIT_T1_GATE_ENABLE = 4;
    localparam int unsigned BIT_T0_OVERFLOW = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] TCFG_RESET = 8'h00;
    localparam logic [1:0] RANGE_CODE_ZERO = 2'b00;
    localparam logic [1:0] RANGE_CODE_LOW = 2'b01;
    localparam logic [1:0] RANGE_CODE_MEDIUM = 2'b10;
    localparam logic [1:0] RANGE_CODE_HIGH = 2'b11;
    localparam logic [1:0] T1_SEL_FOSC4 = 2'b00;
    localparam logic [1:0] T1_SEL_FOSC = 2'b01;
    localparam logic [1:0] T1_SEL_PIN = 2'b10;
    localparam logic [1:0] T1_SEL_SENSE = 2'b11;
    localparam int unsigned TIMER0_W = 8;
    localparam int unsigned TIMER1_W = 16;
    localparam logic [1:0] FOSC_DIV_LAST = 2'h3;
    typedef enum logic [2:0] {
        CSC_OSC_OFF,
        CSC_OSC_NOISE,
        CSC_OSC_LOW,
        CSC_OSC_MEDIUM,
        CSC_OSC_HIGH
    } csc_osc_mode_e;
endpackage

//--- rtl/csc_sync.sv
// Two flip-flop synchroniser for asynchronous level inputs.
`timescale 1ns/10ps
module csc_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule

//--- rtl/csc_counter.sv
// Loadable up counter with a registered wrap pulse.
`timescale 1ns/10ps
module csc_counter #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic inc_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] load_value_i,
    output logic [WIDTH-1:0] count_o,
    output logic wrap_o
);
    // A software load wins over a count in the same cycle.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_o <= '0;
        end else if (load_i) begin
            count_o <= load_value_i;
        end else if (inc_i) begin
            count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wrap_o <= 1'b0;
        end else begin
            wrap_o <= !load_i && inc_i && (&count_o);
        end
    end
endmodule

//--- test/csc_pad_model.sv
// Behavioural capacitive pad and sensing oscillator driving the direction input.
`timescale 1ns/10ps
module csc_pad_model (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic osc_run_i,
    input wire logic current_source_i,
    input wire logic [1:0] current_level_i,
    input wire logic load_i,
    input wire logic noise_i,
    output logic osc_dir_o
);
    logic [7:0] phase;
    logic [7:0] half;
    // Higher current charges the pad faster, and the added finger load slows the ramp.
    assign half = 8'h10 - {4'h0, current_level_i, 2'b00} + (load_i ? 8'h04 : 8'h00);
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase <= 8'h00;
            osc_dir_o <= 1'b0;
        end else if (!osc_run_i) begin
            // A pin that nobody drives shows no stable level.
            phase <= 8'h00;
            osc_dir_o <= ~osc_dir_o;
        end else if (!current_source_i) begin
            osc_dir_o <= noise_i;
        end else if (phase >= half - 8'h01) begin
            phase <= 8'h00;
            osc_dir_o <= ~osc_dir_o;
        end else begin
            phase <= phase + 8'h01;
        end
    end
endmodule

//--- test/capacitive_sense_control_tb.sv
// Self-checking testbench for the capacitive sense control block.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module capacitive_sense_control_tb;
    import csc_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] address = 4'h0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] bus_be = 4'hF;
    logic osc_dir, ext_clk = 1'b0, gate = 1'b0, sleep = 1'b0, load = 1'b0, noise = 1'b0;
    logic [31:0] rdata, avs_readdata;
    logic waitreq, osc_run, ref_var, cur_src, t0_ovf, t1_ovf;
    logic [1:0] cur_lvl;
    logic [7:0] t0_cnt;
    logic [15:0] t1_cnt;
    logic [31:0] d;
    int miscompares = 0;
    int tests_run = 0;
    int nominal, loaded, cyc;
    always #50 sys_clk_i = ~sys_clk_i;
    csc_top dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .avs_address_i(address), .avs_read_i(rd_en),
        .avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(bus_be), .avs_readdata_o(avs_readdata),
        .avs_waitrequest_o(waitreq), .osc_dir_i(osc_dir), .timer0_ext_clock_i(ext_clk), .timer1_gate_i(gate),
        .sleep_i(sleep), .osc_run_o(osc_run), .ref_variable_o(ref_var), .current_source_o(cur_src),
        .current_level_o(cur_lvl), .timer0_count_o(t0_cnt), .timer0_overflow_o(t0_ovf),
        .timer1_count_o(t1_cnt), .timer1_overflow_o(t1_ovf));
    csc_pad_model pad (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .osc_run_i(osc_run), .current_source_i(cur_src),
        .current_level_i(cur_lvl), .load_i(load), .noise_i(noise), .osc_dir_o(osc_dir));
    task automatic bus_access(input logic w, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        address <= a;
        wdata <= wd;
        rd_en <= ~w;
        wr_en <= w;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (waitreq !== 1'b0);
        rdata = avs_readdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        // One wait state puts the answer at the second edge after the request.
        `CHK("bus wait states", 2, n)
    endtask
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wait_overflow(input logic t1, output int n);
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while ((t1 ? t1_ovf : t0_ovf) !== 1'b1);
    endtask
    // The window is counted by the bench itself, never by the timer under test.
    task automatic measure(input logic [3:0] a, input int cyc);
        bus_access(1'b1, a, 32'h0000_0000);
        repeat (cyc) @(posedge sys_clk_i);
        bus_access(1'b0, a, 32'h0000_0000);
    endtask
    task automatic pulse_pin(input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            ext_clk <= 1'b1;
            repeat (4) @(posedge sys_clk_i);
            ext_clk <= 1'b0;
            repeat (4) @(posedge sys_clk_i);
        end
    endtask
    function automatic int exp_count(input int cyc, input int lvl, input logic ld);
        return cyc / (2 * ((16 - 4 * lvl) + (ld ? 4 : 0)));
    endfunction
    function automatic logic near(input logic [31:0] got, input int e);
        return (int'(got) >= e - 2) && (int'(got) <= e + 2);
    endfunction
    task automatic check_reset_values();
        bus_access(1'b0, OFS_SENSE_CONTROL0, 32'h0000_0000);
        `CHK("control reset", {24'h00_0000, CTRL_RESET}, rdata)
        bus_access(1'b0, OFS_TIMER_CONFIG, 32'h0000_0000);
        `CHK("timer config reset", {24'h00_0000, TCFG_RESET}, rdata)
        `CHK("osc off at reset", 1'b0, osc_run)
        $display("test reset values done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #(100 * 30000);
        miscompares++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h6abc58e0));
        repeat (6) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        check_reset_values();
        bus_access(1'b0, 4'h1, 32'h0000_0000);
        `CHK("unmapped read", 32'h0000_0000, rdata)
        for (int i = 0; i < 16; i++) begin
            d = $urandom;
            d[7] = i[3];
            d[6] = i[2];
            d[3:2] = i[1:0];
            bus_access(1'b1, OFS_SENSE_CONTROL0, d);
            wait_cycles(2);
            `CHK("osc run", i[3] && !(i[2] == 1'b0 && i[1:0] == 2'b00), osc_run)
            `CHK("variable refs", i[3] && i[2], ref_var)
            `CHK("current source", i[3] && i[1:0] != 2'b00, cur_src)
            `CHK("current level", (i[3] && i[1:0] != 2'b00) ? i[1:0] : 2'b00, cur_lvl)
            bus_access(1'b0, OFS_SENSE_CONTROL0, 32'h0000_0000);
            `CHK("control readback", d & 32'h0000_00CD, rdata & 32'hFFFF_FFFD)
            if (i < 8) `CHK("status while off", 1'b0, rdata[1])
        end
        bus_be <= 4'hE;
        bus_access(1'b1, OFS_SENSE_CONTROL0, 32'h0000_0000);
        bus_be <= 4'hF;
        bus_access(1'b0, OFS_SENSE_CONTROL0, 32'h0000_0000);
        `CHK("lane0 off ignored", d[7:0] & 8'hCD, rdata[7:0] & 8'hCD)
        $display("test control modes done");
        bus_access(1'b1, OFS_SENSE_CONTROL0, 32'h0000_00C0);
        noise <= 1'b1;
        wait_cycles(6);
        bus_access(1'b0, OFS_SENSE_CONTROL0, 32'h0000_0000);
        `CHK("sourcing status", 1'b1, rdata[1])
        noise <= 1'b0;
        wait_cycles(6);
        bus_access(1'b0, OFS_SENSE_CONTROL0, 32'h0000_0000);
        `CHK("sinking status", 1'b0, rdata[1])
        $display("test direction status done");
        bus_access(1'b1, OFS_SENSE_CONTROL0, 32'h0000_008C);
        bus_access(1'b1, OFS_TIMER_CONFIG, 32'h0000_000E);
        measure(OFS_TIMER1_COUNT, 400);
        nominal = int'(rdata);
        `CHK("timer1 nominal", 1'b1, near(rdata, exp_count(400, 3, 1'b0)))
        load <= 1'b1;
        measure(OFS_TIMER1_COUNT, 400);
        loaded = int'(rdata);
        `CHK("timer1 loaded", 1'b1, near(rdata, exp_count(400, 3, 1'b1)))
        `CHK("threshold between", 1'b1, loaded < (nominal + loaded) / 2 && (nominal + loaded) / 2 < nominal)
        load <= 1'b0;
        sleep <= 1'b1;
        measure(OFS_TIMER1_COUNT, 400);
        `CHK("timer1 in sleep", 1'b1, near(rdata, exp_count(400, 3, 1'b0)))
        sleep <= 1'b0;
        bus_access(1'b1, OFS_TIMER_CONFIG, 32'h0000_001E);
        gate <= 1'b0;
        measure(OFS_TIMER1_COUNT, 200);
        `CHK("timer1 gate closed", 32'h0000_0000, rdata)
        gate <= 1'b1;
        measure(OFS_TIMER1_COUNT, 400);
        `CHK("timer1 gate open", 1'b1, near(rdata, exp_count(400, 3, 1'b0)))
        bus_access(1'b1, OFS_TIMER_CONFIG, 32'h0000_0016);
        measure(OFS_TIMER1_COUNT, 200);
        `CHK("timer1 off", 32'h0000_0000, rdata)
        bus_access(1'b1, OFS_TIMER_CONFIG, 32'h0000_000A);
        bus_access(1'b1, OFS_TIMER1_COUNT, 32'h0000_FFF0);
        wait_overflow(1'b1, cyc);
        `CHK("timer1 free run wrap", (1 << TIMER1_W) - 32'h0000_FFF0 + 1, cyc)
        bus_access(1'b1, OFS_TIMER_CONFIG, 32'h0000_0008);
        measure(OFS_TIMER1_COUNT, 400);
        `CHK("timer1 fosc4", 1'b1, near(rdata, 400 / (FOSC_DIV_LAST + 1)))
        bus_access(1'b1, OFS_TIMER_CONFIG, 32'h0000_000C);
        bus_access(1'b1, OFS_TIMER1_COUNT, 32'h0000_0000);
        pulse_pin(5);
        bus_access(1'b0, OFS_TIMER1_COUNT, 32'h0000_0000);
        `CHK("timer1 pin", 32'h0000_0005, rdata)
        $display("test timer1 done");
        bus_access(1'b1, OFS_SENSE_CONTROL0, 32'h0000_0089);
        bus_access(1'b1, OFS_TIMER_CONFIG, 32'h0000_0001);
        measure(OFS_TIMER0_COUNT, 480);
        `CHK("timer0 sense", 1'b1, near(rdata, exp_count(480, 2, 1'b0)))
        bus_access(1'b1, OFS_SENSE_CONTROL0, 32'h0000_0088);
        bus_access(1'b1, OFS_TIMER0_COUNT, 32'h0000_0000);
        pulse_pin(20);
        bus_access(1'b0, OFS_TIMER0_COUNT, 32'h0000_0000);
        `CHK("timer0 pin", 32'h0000_0014, rdata)
        bus_access(1'b1, OFS_SENSE_CONTROL0, 32'h0000_0089);
        sleep <= 1'b1;
        measure(OFS_TIMER0_COUNT, 300);
        `CHK("timer0 in sleep", 32'h0000_0000, rdata)
        sleep <= 1'b0;
        $display("test timer0 done");
        gate <= 1'b0;
        bus_access(1'b1, OFS_SENSE_CONTROL0, 32'h0000_008C);
        bus_access(1'b1, OFS_TIMER_CONFIG, 32'h0000_001E);
        bus_access(1'b1, OFS_TIMER1_COUNT, 32'h0000_0000);
        wait_overflow(1'b0, cyc);
        gate <= 1'b1;
        wait_overflow(1'b0, cyc);
        gate <= 1'b0;
        `CHK("timer0 wrap period", (1 << TIMER0_W) * (FOSC_DIV_LAST + 1), cyc)
        bus_access(1'b0, OFS_TIMER1_COUNT, 32'h0000_0000);
        `CHK("gated window count", 1'b1, near(rdata, exp_count(cyc, 3, 1'b0)))
        bus_access(1'b0, OFS_TIMER_CONFIG, 32'h0000_0000);
        `CHK("overflow flag set", 1'b1, rdata[BIT_T0_OVERFLOW])
        bus_access(1'b1, OFS_TIMER_CONFIG, 32'h0000_001E);
        bus_access(1'b0, OFS_TIMER_CONFIG, 32'h0000_0000);
        `CHK("overflow flag cleared", 1'b0, rdata[BIT_T0_OVERFLOW])
        $display("test gate time base done");
        @(posedge sys_clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        check_reset_values();
        finish_test();
    end
endmodule
